// ---- pattern_if.sv ----
// Carrier between the request sequencer and the transmit pattern generator.
`timescale 1ns/1ps
interface pattern_if;
  logic start;
  logic advance;
  logic [3:0] sel;
  logic is_data_next;
  modport ctrl (output start, output advance, output sel, input is_data_next);
  modport gen (input start, input advance, input sel, output is_data_next);
endinterface : pattern_if

// ---- sysif_agent.sv ----
// Behavioural external agent that answers reads and returns the interface.
`timescale 1ns/1ps
module sysif_agent (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic bus_oe,
  input wire logic send_null,
  input wire logic hold,
  output logic [8:0] cmd_in,
  output logic [63:0] ad_in,
  output logic valid_in_n
);
  logic [2:0] cnt;

  // While bus_oe is low send four response doublewords or one release null request.
  // Outside its own cycles the agent inverts the buses, so stale values never look valid.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 3'h0;
      valid_in_n <= 1'b1;
      cmd_in <= 9'h1ff;
      ad_in <= 64'h0;
    end else if (!bus_oe && !hold && cnt < (send_null ? 3'h1 : 3'h4)) begin
      cnt <= cnt + 3'h1;
      valid_in_n <= 1'b0;
      cmd_in <= send_null ? 9'h067 : {1'b1, cnt != 3'h3, 7'h1f};
      ad_in <= 64'h0123_4567_89ab_cde0 + 64'(cnt);
    end else begin
      if (bus_oe) cnt <= 3'h0;
      valid_in_n <= 1'b1;
      cmd_in <= ~cmd_in;
      ad_in <= ~ad_in;
    end
  end
endmodule : sysif_agent

// ---- sysif_command_protocol.sv ----
// System interface request sequencer with APB register access.
`timescale 1ns/1ps
`include "sysif_defines.svh"
module sysif_command_protocol #(
  parameter int AD_W = 64,
  parameter int ADDR_W = 36
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [4:0] boot_mode,
  input wire logic mode_reload,
  input wire logic [8:0] request_command_bus_in,
  output logic [8:0] request_command_bus_out,
  output logic request_command_bus_oe,
  input wire logic [AD_W-1:0] shared_addr_data_bus_in,
  output logic [AD_W-1:0] shared_addr_data_bus_out,
  output logic shared_addr_data_bus_oe,
  output logic valid_out_n,
  output logic release_n,
  input wire logic inbound_valid_n,
  input wire logic external_request_n
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  sysif_pkg::state_e st_reg;
  sysif_pkg::cmd_word_t cmd_out_reg;
  logic [31:0] buf_mem [0:7];
  logic [AD_W-1:0] ad_out_reg;
  logic [31:0] addr_lo_reg;
  logic [ADDR_W-33:0] addr_hi_reg;
  logic [7:0] cmd_reg;
  logic [31:0] prdata_reg;
  logic [31:0] rd_mux;
  logic [4:0] ext_cnt_reg;
  logic [3:0] pattern_sel_reg;
  logic [2:0] sent_reg;
  logic [1:0] rcnt_reg;
  logic boot_done_reg, big_endian_reg, rev_endian_reg;
  logic oe_reg, valid_n_reg, release_n_reg;
  logic req_read_reg, req_block_reg, rd_err_reg, refused_reg;
  logic apb_wr, mapped, go_wr, go_ok, release_go, in_release, in_data;
  logic [2:0] total_dw;
  pattern_if pif ();

  tx_pattern u_pattern (
    .pclk(pclk),
    .presetn(presetn),
    .pif(pif)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign apb_wr = psel && penable && pwrite;
  assign mapped = (paddr[1:0] == 2'h0) && (paddr == `REG_CTRL || paddr == `REG_CMD ||
                  paddr == `REG_ADDR_LO || paddr == `REG_ADDR_HI ||
                  paddr == `REG_STATUS || paddr[7:5] == `REG_BUF_PAGE);
  assign go_wr = apb_wr && paddr == `REG_CTRL && pwdata[`CTRL_GO_BIT];
  // An external request pending takes priority over a new processor request.
  assign go_ok = st_reg == sysif_pkg::ST_IDLE && external_request_n &&
                 (cmd_reg[`CMD_TYPE_MSB:`CMD_TYPE_LSB] == `TYPE_READ ||
                  cmd_reg[`CMD_TYPE_MSB:`CMD_TYPE_LSB] == `TYPE_WRITE);
  assign release_go = st_reg == sysif_pkg::ST_IDLE && !external_request_n &&
                      ext_cnt_reg >= `REL_MIN_CNT;
  assign in_release = !inbound_valid_n && !request_command_bus_in[`CMD_KIND_BIT] &&
    request_command_bus_in[`CMD_TYPE_MSB:`CMD_TYPE_LSB] == `TYPE_NULL &&
    request_command_bus_in[`CMD_ATTR_MSB:`CMD_ATTR_LSB] == `NULL_RELEASE;
  assign in_data = !inbound_valid_n && request_command_bus_in[`CMD_KIND_BIT];
  assign total_dw = req_block_reg ? `BLOCK_DWORDS : `SINGLE_DWORDS;
  assign pif.start = st_reg == sysif_pkg::ST_ADDR;
  assign pif.advance = st_reg == sysif_pkg::ST_DATA;
  assign pif.sel = pattern_sel_reg;

  // Doubleword assembly honours the latched interface byte order only.
  function automatic logic [63:0] dword_of(input logic [1:0] idx);
    logic [31:0] w0;
    logic [31:0] w1;
    w0 = buf_mem[{idx, 1'b0}];
    w1 = buf_mem[{idx, 1'b1}];
    dword_of = big_endian_reg ? {w0, w1} : {w1, w0};
  endfunction : dword_of

  // ----------------------------------------------------------------
  // Boot mode straps
  // ----------------------------------------------------------------
  // Straps are caught after reset release, then held until a reload pulse.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_done_reg <= 1'b0;
      big_endian_reg <= 1'b0;
      pattern_sel_reg <= 4'h0;
    end else if (!boot_done_reg || mode_reload) begin
      boot_done_reg <= 1'b1;
      big_endian_reg <= boot_mode[`BOOT_ENDIAN_BIT];
      pattern_sel_reg <= boot_mode[`BOOT_PAT_MSB:`BOOT_PAT_LSB];
    end
  end

  // ----------------------------------------------------------------
  // Release latency
  // ----------------------------------------------------------------
  // Counts cycles of a held external request; the minimum wait hides internal activity.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_cnt_reg <= 5'h00;
    end else if (external_request_n) begin
      ext_cnt_reg <= 5'h00;
    end else if (ext_cnt_reg != `EXT_CNT_SAT) begin
      ext_cnt_reg <= ext_cnt_reg + 5'h01;
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  // Control, command and address registers; the refused flag sets over a clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_reg <= 8'h00;
      addr_lo_reg <= 32'h0000_0000;
      addr_hi_reg <= '0;
      rev_endian_reg <= 1'b0;
      refused_reg <= 1'b0;
    end else begin
      if (apb_wr && paddr == `REG_CMD) cmd_reg <= pwdata[7:0];
      if (apb_wr && paddr == `REG_ADDR_LO) addr_lo_reg <= pwdata;
      if (apb_wr && paddr == `REG_ADDR_HI) addr_hi_reg <= pwdata[ADDR_W-33:0];
      if (apb_wr && paddr == `REG_CTRL) rev_endian_reg <= pwdata[`CTRL_REV_BIT];
      if (go_wr && !go_ok) begin
        refused_reg <= 1'b1;
      end else if (apb_wr && paddr == `REG_CTRL && pwdata[`CTRL_CLR_BIT]) begin
        refused_reg <= 1'b0;
      end
    end
  end

  // Read data is registered in the setup phase so the access phase needs no wait.
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (paddr == `REG_CTRL) rd_mux[`CTRL_REV_BIT] = rev_endian_reg;
    else if (paddr == `REG_CMD) rd_mux[7:0] = cmd_reg;
    else if (paddr == `REG_ADDR_LO) rd_mux = addr_lo_reg;
    else if (paddr == `REG_ADDR_HI) rd_mux[ADDR_W-33:0] = addr_hi_reg;
    else if (paddr == `REG_STATUS) rd_mux[12:0] = {pattern_sel_reg, refused_reg, rd_err_reg,
      big_endian_reg ^ rev_endian_reg, big_endian_reg, st_reg};
    else if (paddr[7:5] == `REG_BUF_PAGE) rd_mux = buf_mem[paddr[4:2]];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_reg <= mapped ? rd_mux : 32'h0000_0000;
    end
  end

  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ----------------------------------------------------------------
  // Data buffer
  // ----------------------------------------------------------------
  // Software fills the block to send; read response data lands in the same words.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 8; i++) buf_mem[i] <= 32'h0000_0000;
      rcnt_reg <= 2'h0;
      rd_err_reg <= 1'b0;
    end else if (st_reg == sysif_pkg::ST_RESP && in_data) begin
      buf_mem[{rcnt_reg, 1'b0}] <= big_endian_reg ? shared_addr_data_bus_in[63:32]
                                                  : shared_addr_data_bus_in[31:0];
      buf_mem[{rcnt_reg, 1'b1}] <= big_endian_reg ? shared_addr_data_bus_in[31:0]
                                                  : shared_addr_data_bus_in[63:32];
      if (rcnt_reg == 2'h0) rd_err_reg <= request_command_bus_in[`DID_ERR_BIT];
      rcnt_reg <= rcnt_reg + 2'h1;
    end else begin
      if (apb_wr && paddr[7:5] == `REG_BUF_PAGE) buf_mem[paddr[4:2]] <= pwdata;
      if (go_wr && go_ok) rcnt_reg <= 2'h0;
    end
  end

  // ----------------------------------------------------------------
  // Interface sequencer
  // ----------------------------------------------------------------
  // Bus values change only on real address or data cycles, so idle cycles hold data.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= sysif_pkg::ST_IDLE;
      cmd_out_reg <= 9'h000;
      ad_out_reg <= '0;
      oe_reg <= 1'b1;
      valid_n_reg <= 1'b1;
      release_n_reg <= 1'b1;
      sent_reg <= 3'h0;
      req_read_reg <= 1'b0;
      req_block_reg <= 1'b0;
    end else begin
      case (st_reg)
        sysif_pkg::ST_IDLE: begin
          if (release_go) begin
            st_reg <= sysif_pkg::ST_SLAVE;
            release_n_reg <= 1'b0;
            oe_reg <= 1'b0;
          end else if (go_wr && go_ok) begin
            st_reg <= sysif_pkg::ST_ADDR;
            cmd_out_reg <= {1'b0, cmd_reg};
            ad_out_reg <= {{(AD_W-ADDR_W){1'b0}}, addr_hi_reg, addr_lo_reg};
            valid_n_reg <= 1'b0;
            req_read_reg <= cmd_reg[`CMD_TYPE_MSB:`CMD_TYPE_LSB] == `TYPE_READ;
            req_block_reg <= cmd_reg[`CMD_ATTR_MSB:`CMD_ATTR_LSB] == `ATTR_BLOCK;
            // A read releases the interface in its own address cycle.
            release_n_reg <= cmd_reg[`CMD_TYPE_MSB:`CMD_TYPE_LSB] != `TYPE_READ;
          end
        end
        sysif_pkg::ST_ADDR: begin
          release_n_reg <= 1'b1;
          if (req_read_reg) begin
            st_reg <= sysif_pkg::ST_RESP;
            oe_reg <= 1'b0;
            valid_n_reg <= 1'b1;
          end else begin
            st_reg <= sysif_pkg::ST_DATA;
            ad_out_reg <= dword_of(2'h0);
            cmd_out_reg <= {1'b1, total_dw != `SINGLE_DWORDS, 1'b1, 1'b0,
                            `DID_RESERVED};
            valid_n_reg <= 1'b0;
            sent_reg <= 3'h1;
          end
        end
        sysif_pkg::ST_DATA: begin
          if (sent_reg == total_dw) begin
            st_reg <= sysif_pkg::ST_IDLE;
            valid_n_reg <= 1'b1;
          end else if (pif.is_data_next) begin
            ad_out_reg <= dword_of(sent_reg[1:0]);
            cmd_out_reg <= {1'b1, sent_reg != total_dw - 3'h1, 1'b1, 1'b0,
                            `DID_RESERVED};
            valid_n_reg <= 1'b0;
            sent_reg <= sent_reg + 3'h1;
          end else begin
            valid_n_reg <= 1'b1;
          end
        end
        sysif_pkg::ST_SLAVE: begin
          release_n_reg <= 1'b1;
          // Third-party traffic never asserts inbound valid, so only the release acts.
          if (in_release) begin
            st_reg <= sysif_pkg::ST_IDLE;
            oe_reg <= 1'b1;
          end
        end
        sysif_pkg::ST_RESP: begin
          if (in_data && !request_command_bus_in[`DID_LAST_BIT]) begin
            st_reg <= sysif_pkg::ST_IDLE;
            oe_reg <= 1'b1;
          end
        end
        default: begin
          st_reg <= sysif_pkg::ST_IDLE;
          oe_reg <= 1'b1;
          valid_n_reg <= 1'b1;
          release_n_reg <= 1'b1;
        end
      endcase
    end
  end

  assign request_command_bus_out = cmd_out_reg;
  assign request_command_bus_oe = oe_reg;
  assign shared_addr_data_bus_out = ad_out_reg;
  assign shared_addr_data_bus_oe = oe_reg;
  assign valid_out_n = valid_n_reg;
  assign release_n = release_n_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_write_addr;
    st_reg == sysif_pkg::ST_ADDR && !req_read_reg;
  endsequence
  sequence s_first_dword;
    !valid_n_reg && cmd_out_reg[`CMD_KIND_BIT] && st_reg == sysif_pkg::ST_DATA;
  endsequence

  a_first_data_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    s_write_addr |=> s_first_dword)
    else $error("block write did not open with a data cycle");
  a_idle_holds_data: assert property (@(posedge pclk) disable iff (!presetn)
    (oe_reg && valid_n_reg) |-> $stable(ad_out_reg))
    else $error("bus value changed in an unused cycle");
  a_release_window: assert property (@(posedge pclk) disable iff (!presetn)
    (st_reg == sysif_pkg::ST_IDLE && $fell(external_request_n))
      |-> ##[4:24] !release_n_reg)
    else $error("release not given within the latency window");
  a_release_minimum: assert property (@(posedge pclk) disable iff (!presetn)
    (!release_n_reg && st_reg == sysif_pkg::ST_SLAVE) |-> ext_cnt_reg >= 5'h04)
    else $error("compelled release came too early");
  a_read_zero_latency: assert property (@(posedge pclk) disable iff (!presetn)
    (!valid_n_reg && !cmd_out_reg[`CMD_KIND_BIT] &&
     cmd_out_reg[`CMD_TYPE_MSB:`CMD_TYPE_LSB] == `TYPE_READ) |-> !release_n_reg)
    else $error("read request did not release in its own cycle");
  a_cmd_kind_bit: assert property (@(posedge pclk) disable iff (!presetn)
    !valid_n_reg |-> cmd_out_reg[`CMD_KIND_BIT] == (st_reg == sysif_pkg::ST_DATA))
    else $error("kind bit does not match cycle type");
  a_cmd_type_legal: assert property (@(posedge pclk) disable iff (!presetn)
    (!valid_n_reg && !cmd_out_reg[`CMD_KIND_BIT]) |->
      cmd_out_reg[`CMD_TYPE_MSB:`CMD_TYPE_LSB] inside {`TYPE_READ, `TYPE_WRITE})
    else $error("processor issued a reserved request type");
  a_null_release: assert property (@(posedge pclk) disable iff (!presetn)
    (st_reg == sysif_pkg::ST_SLAVE && in_release) |=> (st_reg == sysif_pkg::ST_IDLE &&
      oe_reg))
    else $error("release null request did not restore master state");
  a_endian_fixed: assert property (@(posedge pclk) disable iff (!presetn)
    (boot_done_reg && !mode_reload) |=> $stable(big_endian_reg))
    else $error("interface byte order changed without a mode reload");
endmodule : sysif_command_protocol

// ---- sysif_defines.svh ----
// Constant definitions shared by the system interface command logic.
`ifndef SYSIF_DEFINES_SVH
`define SYSIF_DEFINES_SVH

// ----------------------------------------------------------------
// Command and data identifier fields
// ----------------------------------------------------------------
`define CMD_KIND_BIT 8
`define CMD_TYPE_MSB 7
`define CMD_TYPE_LSB 5
`define CMD_ATTR_MSB 4
`define CMD_ATTR_LSB 3
`define CMD_RESERVED_LOW 3'h7
`define TYPE_READ 3'h0
`define TYPE_WRITE 3'h2
`define TYPE_NULL 3'h3
`define ATTR_BLOCK 2'h2
`define ATTR_SINGLE 2'h3
`define NULL_RELEASE 2'h0
`define DID_LAST_BIT 7
`define DID_RESP_BIT 6
`define DID_ERR_BIT 5
`define DID_RESERVED 5'h1f
`define BLOCK_DWORDS 3'h4
`define SINGLE_DWORDS 3'h1

// ----------------------------------------------------------------
// Release latency and boot mode straps
// ----------------------------------------------------------------
`define REL_MIN_CNT 5'h03
`define EXT_CNT_SAT 5'h1f
`define BOOT_PAT_MSB 3
`define BOOT_PAT_LSB 0
`define BOOT_ENDIAN_BIT 4

// ----------------------------------------------------------------
// Register offsets and fields
// ----------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_CMD 8'h04
`define REG_ADDR_LO 8'h08
`define REG_ADDR_HI 8'h0c
`define REG_STATUS 8'h10
`define REG_BUF_PAGE 3'h1
`define CTRL_GO_BIT 0
`define CTRL_REV_BIT 1
`define CTRL_CLR_BIT 2

// ----------------------------------------------------------------
// Transmit patterns: mask bit i marks a data cycle, LAST is the final position
// ----------------------------------------------------------------
`define PAT0_MASK 8'h01
`define PAT0_LAST 3'h0
`define PAT1_MASK 8'h03
`define PAT1_LAST 3'h2
`define PAT2_MASK 8'h03
`define PAT2_LAST 3'h3
`define PAT3_MASK 8'h01
`define PAT3_LAST 3'h1
`define PAT4_MASK 8'h03
`define PAT4_LAST 3'h4
`define PAT5_MASK 8'h03
`define PAT5_LAST 3'h5
`define PAT6_MASK 8'h01
`define PAT6_LAST 3'h2
`define PAT7_MASK 8'h03
`define PAT7_LAST 3'h7
`define PAT8_MASK 8'h01
`define PAT8_LAST 3'h3

`endif

// ---- sysif_pkg.sv ----
// Types shared by the system interface command logic.
package sysif_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_DATA = 5'h04,
    ST_SLAVE = 5'h08,
    ST_RESP = 5'h10
  } state_e;
  typedef logic [8:0] cmd_word_t;
endpackage : sysif_pkg

// ---- tb_sysif_command_protocol.sv ----
// Self-checking bench for the system interface request sequencer.
`timescale 1ns/1ps
module tb_sysif_command_protocol;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, mode_reload = 0;
  logic pready, pslverr, cmd_oe, ad_oe, valid_out_n, release_n, valid_in_n, err;
  logic ext_n = 1, send_null = 0, hold = 0;
  logic [7:0] paddr = 8'h00;
  logic [4:0] boot_mode = 5'h10;
  logic [8:0] cmd_out, cmd_in;
  logic [31:0] pwdata = 32'h0, prdata, rd, w [8];
  logic [63:0] ad_out, ad_in, last;
  logic [63:0] q [$];
  int n_errors = 0, checked = 0, seed = 3660, k, n, pos;
  string pat [9] = '{"DDDD", "DDx", "DDxx", "Dx", "DDxxx", "DDxxxx", "Dxx", "DDxxxxxx", "Dxxx"};

  // Free-running 10 MHz clock.
  always #50 pclk = ~pclk;

  sysif_command_protocol i_sysif_command_protocol (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .boot_mode(boot_mode), .mode_reload(mode_reload), .request_command_bus_in(cmd_in),
    .request_command_bus_out(cmd_out), .request_command_bus_oe(cmd_oe),
    .shared_addr_data_bus_in(ad_in), .shared_addr_data_bus_out(ad_out),
    .shared_addr_data_bus_oe(ad_oe), .valid_out_n(valid_out_n), .release_n(release_n),
    .inbound_valid_n(valid_in_n), .external_request_n(ext_n));
  sysif_agent i_sysif_agent (.pclk(pclk), .presetn(presetn), .bus_oe(ad_oe),
    .send_null(send_null), .hold(hold), .cmd_in(cmd_in), .ad_in(ad_in), .valid_in_n(valid_in_n));

  task automatic wrap_up();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // A used-up wait ends the run at once, since later steps would only cascade.
  task automatic bound(input bit ok);
    if (!ok) begin
      n_errors++;
      $display("Error wait bound used up");
      wrap_up();
    end
  endtask : bound

  // One APB transfer; always starts on a fresh edge so no signal is driven twice at once.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    bound(i < 20);
  endtask : apb

  // Write of nd doublewords under pattern p; odd p also selects big-endian straps.
  task automatic blk_write(input int p, input int nd);
    int m;
    logic [31:0] a;
    @(posedge pclk);
    boot_mode <= {p[0], p[3:0]};
    mode_reload <= 1'b1;
    @(posedge pclk);
    mode_reload <= 1'b0;
    a = $random(seed) & 32'hffff_fff8;
    for (m = 0; m < 8; m++) begin
      w[m] = $random(seed);
      apb(1'b1, 8'h20 + 8'(4 * m), w[m]);
    end
    for (m = 0; m < nd; m++) begin
      q.push_back(p[0] ? {w[2*m], w[2*m+1]} : {w[2*m+1], w[2*m]});
    end
    apb(1'b1, 8'h08, a);
    apb(1'b1, 8'h04, nd == 4 ? 32'h51 : 32'h5f);
    apb(1'b1, 8'h00, 32'h1);
    @(negedge pclk);
    chk("addr valid", 0, valid_out_n);
    chk("write cmd", nd == 4 ? 9'h051 : 9'h05f, cmd_out);
    chk("address", a, ad_out[31:0]);
    n = 0;
    pos = 0;
    for (m = 0; n < nd && m < 40; m++) begin
      @(negedge pclk);
      if (pat[p][pos] == "D") begin
        last = q.pop_front();
        chk("data valid", 0, valid_out_n);
        chk("data", last, ad_out);
        chk("data id", {1'b1, n != nd - 1, 2'b10}, cmd_out[8:5]);
        n++;
      end else begin
        chk("idle valid", 1, valid_out_n);
        chk("idle data", last, ad_out);
      end
      pos = (pos + 1) % pat[p].len();
    end
    bound(n == nd);
    @(negedge pclk);
    chk("after valid", 1, valid_out_n);
    chk("after data", last, ad_out);
    $display("block write pattern %0d done", p);
  endtask : blk_write

  // Main sequence: registers, every pattern twice, one single-doubleword write, a read, then an external request.
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("idle oe", 1, ad_oe);
    chk("idle valid", 1, valid_out_n);
    chk("idle release", 1, release_n);
    apb(1'b0, 8'h10, 32'h0);
    chk("status", 6'h21, rd[5:0]);
    apb(1'b1, 8'h00, 32'h2);
    apb(1'b0, 8'h10, 32'h0);
    chk("endian kept", 2'b01, rd[6:5]);
    apb(1'b0, 8'h80, 32'h0);
    chk("unmapped err", 1, err);
    apb(1'b1, 8'h04, 32'h60);
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    chk("refused", 1, rd[8]);
    apb(1'b1, 8'h00, 32'h4);
    apb(1'b0, 8'h10, 32'h0);
    chk("refused clear", 0, rd[8]);
    $display("register test done");
    for (k = 0; k < 19; k++) blk_write(k % 9, k < 18 ? 4 : 1);
    apb(1'b1, 8'h04, 32'h11);
    apb(1'b1, 8'h00, 32'h1);
    @(negedge pclk);
    chk("read cmd", 9'h011, cmd_out);
    chk("uncompelled release", 0, release_n);
    for (k = 0; k < 30; k++) begin
      @(negedge pclk);
      if (ad_oe === 1'b1) break;
    end
    bound(k > 0 && k < 30);
    for (k = 0; k < 8; k++) begin
      apb(1'b0, 8'h20 + 8'(4 * k), 32'h0);
      last = 64'h0123_4567_89ab_cde0 + 64'(k / 2);
      chk("read data", k[0] ? last[63:32] : last[31:0], rd);
    end
    $display("read test done");
    @(posedge pclk);
    send_null <= 1'b1;
    hold <= 1'b1;
    ext_n <= 1'b0;
    for (k = 0; k < 30; k++) begin
      @(negedge pclk);
      if (release_n === 1'b0) break;
    end
    bound(k < 30);
    chk("release latency", 1, k >= 4 && k <= 24);
    repeat (5) @(negedge pclk);
    chk("slave oe", 0, ad_oe);
    chk("slave cmd oe", 0, cmd_oe);
    @(posedge pclk);
    ext_n <= 1'b1;
    hold <= 1'b0;
    for (k = 0; k < 30; k++) begin
      @(negedge pclk);
      if (ad_oe === 1'b1) break;
    end
    bound(k < 30);
    $display("external request test done");
    wrap_up();
  end
endmodule : tb_sysif_command_protocol

// ---- tx_pattern.sv ----
// Block write transmit pattern generator.
`timescale 1ns/1ps
`include "sysif_defines.svh"
module tx_pattern (
  input wire logic pclk,
  input wire logic presetn,
  pattern_if.gen pif
);
  logic [2:0] pos_reg;
  logic [2:0] pos_next;
  logic [7:0] mask;
  logic [2:0] last;

  // Unknown selections fall back to the full rate pattern.
  always_comb begin
    case (pif.sel)
      4'h1: begin mask = `PAT1_MASK; last = `PAT1_LAST; end
      4'h2: begin mask = `PAT2_MASK; last = `PAT2_LAST; end
      4'h3: begin mask = `PAT3_MASK; last = `PAT3_LAST; end
      4'h4: begin mask = `PAT4_MASK; last = `PAT4_LAST; end
      4'h5: begin mask = `PAT5_MASK; last = `PAT5_LAST; end
      4'h6: begin mask = `PAT6_MASK; last = `PAT6_LAST; end
      4'h7: begin mask = `PAT7_MASK; last = `PAT7_LAST; end
      4'h8: begin mask = `PAT8_MASK; last = `PAT8_LAST; end
      default: begin mask = `PAT0_MASK; last = `PAT0_LAST; end
    endcase
  end

  // The pattern repeats by wrapping at its last position.
  assign pos_next = (pos_reg == last) ? 3'h0 : pos_reg + 3'h1;
  assign pif.is_data_next = mask[pos_next];

  // Each block write restarts the pattern at its first position.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_reg <= 3'h0;
    end else if (pif.start) begin
      pos_reg <= 3'h0;
    end else if (pif.advance) begin
      pos_reg <= pos_next;
    end
  end

  a_pattern_restart: assert property (@(posedge pclk) disable iff (!presetn)
    pif.start |=> pos_reg == 3'h0)
    else $error("pattern did not restart at block start");
  a_pattern_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    (pif.advance && !pif.start && pos_reg == last) |=> pos_reg == 3'h0)
    else $error("pattern did not wrap after its last position");
endmodule : tx_pattern
